// >>> epsc_pkg.sv
// Constants, register map and mode codes of the position and edge counter.
// Assumes a 32-bit APB slave on pclk; all users qualify names explicitly.
//
// Overview of operation
// RQ1: single-edge: count up on A rise, A leading
// RQ2: single-edge: count down on A fall, B leading
// RQ3: double-edge: step on both A edges
// RQ4: quad-edge: step on every A and B edge
// RQ5: index high in chosen phase loads reload
// RQ6: software picks the index reload phase
// RQ7: count step first, reload afterwards
// RQ8: reload done within one slow timebase period
// RQ9: keep counting from reloaded value
// RQ10: index must be high in chosen phase
// RQ11: two-pulse: A rise counts up
// RQ12: two-pulse: B rise counts down
// RQ13: count only after arming
// RQ14: sample edge captures count, never clears
// RQ15: each sample handed to DMA
// RQ16: sample clock on gate, edge selectable
// RQ17: armed aux edge starts source counting
// RQ18: aux edges ignored while interval runs
// RQ19: gate edge stops and latches count
// RQ20: aux and gate active edges selectable
// RQ21: single mode holds value, ignores edges
// RQ22: buffered mode restarts at next gate edge
// RQ23: counter is 32 bits wide
// RQ24: synchronise all pins before edge detection
package epsc_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int CNT_W  = 32;
	localparam int ADDR_W = 8;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SAVE   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int CTRL_ARM     = 0;
	localparam int CTRL_MODE_LO = 1; // three bits
	localparam int CTRL_PH_LO   = 4; // two bits: {A,B} level
	localparam int CTRL_IDX_EN  = 6;
	localparam int CTRL_GATE_F  = 7;
	localparam int CTRL_AUX_F   = 8;
	localparam int CTRL_SRC_F   = 9;
	localparam int CTRL_W       = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

	// ------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------
	localparam int ST_RUN  = 0;
	localparam int ST_DONE = 1;

	// ------------------------------------------------------------
	// Modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_SINGLE_EDGE = 3'h0, // single_edge_decoding
		MODE_DOUBLE_EDGE = 3'h1, // double_edge_decoding
		MODE_QUAD_EDGE   = 3'h2, // quad_edge_decoding
		MODE_TWO_PULSE   = 3'h3,
		MODE_SEP_SINGLE  = 3'h4,
		MODE_SEP_BUF     = 3'h5
	} epsc_mode_t;

	// Separation measurement states
	typedef enum logic [1:0] {
		SEP_IDLE = 2'b00,
		SEP_RUN  = 2'b01,
		SEP_HOLD = 2'b10,
		SEP_WAIT = 2'b11
	} epsc_sep_t;

	// ------------------------------------------------------------
	// Timing: slowest timebase period bounds index reload latency
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int SLOW_TB_PS      = 10000000; // 100 kHz timebase
	localparam int RELOAD_MAX_CYC  = SLOW_TB_PS / CLK_PERIOD_PS;
	localparam int SYNC_LAT        = 4; // pin to register update

	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

endpackage : epsc_pkg

// >>> epsc_counter.sv
// Encoder position and two-signal edge-separation counter, APB slave.
// Assumes pins are asynchronous to pclk and DMA drains on dma_ready.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module epsc_counter (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Encoder and signal pins
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        enc_index,
	input  wire logic        gate_in,
	input  wire logic        aux_in,
	input  wire logic        source_in,
	// DMA request stream
	output logic             dma_valid,
	input  wire logic        dma_ready,
	output var  logic [31:0] dma_data
);

	// ------------------------------------------------------------
	// Input synchronisers: three stages, change on stages 2 and 3
	// ------------------------------------------------------------
	logic [2:0] sa_reg, sb_reg, sz_reg, sg_reg, sx_reg, ss_reg;
	logic       a_reg, b_reg, z_reg, g_reg, x_reg, s_reg;
	logic       a_prev_reg, b_prev_reg, g_prev_reg, x_prev_reg, s_prev_reg;

	// Filtered level holds until stages two and three agree
	function automatic logic filt(input logic [2:0] sh, input logic old);
		filt = (sh[1] == sh[2]) ? sh[2] : old;
	endfunction : filt

	// Edge detect with selectable polarity
	function automatic logic act_edge(input logic cur, input logic prev,
	                                  input logic fall);
		act_edge = fall ? (prev & ~cur) : (cur & ~prev);
	endfunction : act_edge

	// Sync chain; stage 0 only feeds stage 1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sa_reg <= 3'h0;
			sb_reg <= 3'h0;
			sz_reg <= 3'h0;
			sg_reg <= 3'h0;
			sx_reg <= 3'h0;
			ss_reg <= 3'h0;
		end else begin
			sa_reg <= {sa_reg[1:0], enc_a}; // RQ24
			sb_reg <= {sb_reg[1:0], enc_b};
			sz_reg <= {sz_reg[1:0], enc_index};
			sg_reg <= {sg_reg[1:0], gate_in};
			sx_reg <= {sx_reg[1:0], aux_in};
			ss_reg <= {ss_reg[1:0], source_in};
		end
	end

	// Clean levels and previous values of all but the index level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{a_reg, b_reg, z_reg, g_reg, x_reg, s_reg} <= 6'h00;
			{a_prev_reg, b_prev_reg, g_prev_reg} <= 3'h0;
			{x_prev_reg, s_prev_reg} <= 2'h0;
		end else begin
			a_reg      <= filt(sa_reg, a_reg); // RQ24
			b_reg      <= filt(sb_reg, b_reg);
			z_reg      <= filt(sz_reg, z_reg);
			g_reg      <= filt(sg_reg, g_reg);
			x_reg      <= filt(sx_reg, x_reg);
			s_reg      <= filt(ss_reg, s_reg);
			a_prev_reg <= a_reg;
			b_prev_reg <= b_reg;
			g_prev_reg <= g_reg;
			x_prev_reg <= x_reg;
			s_prev_reg <= s_reg;
		end
	end

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	logic [epsc_pkg::CTRL_W-1:0] ctrl_reg;
	logic [epsc_pkg::CNT_W-1:0]  reload_reg;
	logic [epsc_pkg::CNT_W-1:0]  count_reg, count_next;
	logic [epsc_pkg::CNT_W-1:0]  save_reg;
	logic                        done_reg;
	epsc_pkg::epsc_sep_t         sep_reg, sep_next;

	wire logic       armed  = ctrl_reg[epsc_pkg::CTRL_ARM];
	wire logic [2:0] mode_f = ctrl_reg[epsc_pkg::CTRL_MODE_LO +: 3];
	wire logic [1:0] phase  = ctrl_reg[epsc_pkg::CTRL_PH_LO +: 2];
	wire logic       idx_en = ctrl_reg[epsc_pkg::CTRL_IDX_EN];
	wire epsc_pkg::epsc_mode_t mode = epsc_pkg::epsc_mode_t'(mode_f);

	// ------------------------------------------------------------
	// Encoder edge decoding
	// ------------------------------------------------------------
	wire logic a_rise = a_reg & ~a_prev_reg;
	wire logic a_fall = ~a_reg & a_prev_reg;
	wire logic b_rise = b_reg & ~b_prev_reg;
	wire logic b_fall = ~b_reg & b_prev_reg;
	wire logic a_chg  = a_rise | a_fall;
	wire logic b_chg  = b_rise | b_fall;
	// Direction: A leads when A edge lands with A != B, etc.
	wire logic a_dir_up = a_reg ^ b_reg;   // A edge, A leading
	wire logic b_dir_up = ~(a_reg ^ b_reg); // B edge, A leading
	wire logic is_sep = (mode == epsc_pkg::MODE_SEP_SINGLE) ||
	                    (mode == epsc_pkg::MODE_SEP_BUF);

	logic inc, dec;
	// Step decision per decoding mode
	always_comb begin
		inc = 1'b0;
		dec = 1'b0;
		case (mode)
			epsc_pkg::MODE_SINGLE_EDGE: begin
				inc = a_rise & a_dir_up;        // RQ1
				dec = a_fall & ~a_dir_up;       // RQ2
			end
			epsc_pkg::MODE_DOUBLE_EDGE: begin
				inc = a_chg & a_dir_up;         // RQ3
				dec = a_chg & ~a_dir_up;        // RQ3
			end
			epsc_pkg::MODE_QUAD_EDGE: begin
				inc = (a_chg & a_dir_up) | (b_chg & b_dir_up);   // RQ4
				dec = (a_chg & ~a_dir_up) | (b_chg & ~b_dir_up); // RQ4
			end
			epsc_pkg::MODE_TWO_PULSE: begin
				// Simultaneous rises cancel rather than drift
				inc = a_rise & ~b_rise;         // RQ11
				dec = b_rise & ~a_rise;         // RQ12
			end
			default: begin
				inc = 1'b0;
				dec = 1'b0;
			end
		endcase
	end

	// Index reload: phase is the {A,B} level pair, index high
	wire logic quad_mode = (mode == epsc_pkg::MODE_SINGLE_EDGE) ||
	                       (mode == epsc_pkg::MODE_DOUBLE_EDGE) ||
	                       (mode == epsc_pkg::MODE_QUAD_EDGE);
	wire logic reload_hit = quad_mode & idx_en & z_reg &
	                        ({a_reg, b_reg} == phase); // RQ5 RQ6

	// ------------------------------------------------------------
	// Edge separation controls
	// ------------------------------------------------------------
	wire logic gate_act = act_edge(g_reg, g_prev_reg,
	                               ctrl_reg[epsc_pkg::CTRL_GATE_F]); // RQ20
	wire logic aux_act  = act_edge(x_reg, x_prev_reg,
	                               ctrl_reg[epsc_pkg::CTRL_AUX_F]);  // RQ20
	wire logic src_act  = act_edge(s_reg, s_prev_reg,
	                               ctrl_reg[epsc_pkg::CTRL_SRC_F]);

	// Sample edge for buffered position uses the gate edge
	wire logic quad_or_tp = quad_mode | (mode == epsc_pkg::MODE_TWO_PULSE);
	wire logic sample_ev = armed & quad_or_tp & gate_act; // RQ16

	logic latch_ev;
	// Separation state machine
	always_comb begin
		sep_next = sep_reg;
		latch_ev = 1'b0;
		case (sep_reg)
			epsc_pkg::SEP_IDLE:
				if (armed && is_sep && aux_act)
					sep_next = epsc_pkg::SEP_RUN;     // RQ17
			epsc_pkg::SEP_RUN:
				// Further aux edges fall through unheeded
				if (gate_act) begin                    // RQ18
					latch_ev = 1'b1;                    // RQ19
					sep_next = (mode == epsc_pkg::MODE_SEP_BUF) ?
					           epsc_pkg::SEP_WAIT : epsc_pkg::SEP_HOLD;
				end
			epsc_pkg::SEP_HOLD:
				sep_next = epsc_pkg::SEP_HOLD;        // RQ21
			epsc_pkg::SEP_WAIT:
				if (gate_act)
					sep_next = epsc_pkg::SEP_RUN;     // RQ22
			default:
				sep_next = epsc_pkg::SEP_IDLE;
		endcase
		if (!armed || !is_sep)
			sep_next = epsc_pkg::SEP_IDLE;
	end

	// Count next value: step first, then reload overrides
	always_comb begin
		count_next = count_reg;
		if (!armed) begin
			count_next = count_reg;                 // RQ13
		end else if (is_sep) begin
			if (latch_ev || (sep_reg != epsc_pkg::SEP_RUN &&
			                 sep_next == epsc_pkg::SEP_RUN))
				count_next = '0;
			else if (sep_reg == epsc_pkg::SEP_RUN && src_act)
				count_next = count_reg + epsc_pkg::CNT_ONE;
		end else begin
			if (inc)
				count_next = count_reg + epsc_pkg::CNT_ONE; // RQ9
			else if (dec)
				count_next = count_reg - epsc_pkg::CNT_ONE;
			if (reload_hit)
				count_next = reload_reg;            // RQ7 RQ8
		end
	end

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire logic acc     = psel & penable;
	wire logic wr      = acc & pwrite;
	wire logic hit_ctl = paddr == epsc_pkg::OFS_CTRL;
	wire logic hit_rl  = paddr == epsc_pkg::OFS_RELOAD;
	wire logic hit_cnt = paddr == epsc_pkg::OFS_COUNT;
	wire logic hit_sv  = paddr == epsc_pkg::OFS_SAVE;
	wire logic hit_st  = paddr == epsc_pkg::OFS_STATUS;
	wire logic mapped  = hit_ctl | hit_rl | hit_cnt | hit_sv | hit_st;
	wire logic arm_now = wr & hit_ctl & pwdata[epsc_pkg::CTRL_ARM] & ~armed;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	logic [31:0] rd_mux;
	// Read mux; unmapped reads return zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctl)
			rd_mux[epsc_pkg::CTRL_W-1:0] = ctrl_reg;
		else if (hit_rl)
			rd_mux = reload_reg;
		else if (hit_cnt)
			rd_mux = count_reg;
		else if (hit_sv)
			rd_mux = save_reg;
		else if (hit_st) begin
			rd_mux[epsc_pkg::ST_RUN]  = (sep_reg == epsc_pkg::SEP_RUN);
			rd_mux[epsc_pkg::ST_DONE] = done_reg;
		end
	end

	// Read word taken in the setup cycle, so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable)
			prdata <= rd_mux;
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg   <= epsc_pkg::CTRL_RST;
			reload_reg <= '0;
		end else begin
			if (wr && hit_ctl)
				ctrl_reg <= pwdata[epsc_pkg::CTRL_W-1:0];
			if (wr && hit_rl)
				reload_reg <= pwdata;
		end
	end

	// Counter, save register and state; arming clears the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
			save_reg  <= '0;
			done_reg  <= 1'b0;
			sep_reg   <= epsc_pkg::SEP_IDLE;
		end else begin
			count_reg <= arm_now ? '0 : count_next; // RQ23
			sep_reg   <= sep_next;
			if (latch_ev)
				save_reg <= count_reg;              // RQ19
			// Latch wins over a same-cycle arming clear
			if (latch_ev)
				done_reg <= 1'b1;
			else if (arm_now)
				done_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// DMA output: one word holding register, stalls by overwrite
	// ------------------------------------------------------------
	// No buffering: an unaccepted word is replaced by the newer one
	wire logic dma_push = sample_ev |                              // RQ14
	                      (latch_ev & (mode == epsc_pkg::MODE_SEP_BUF));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_valid <= 1'b0;
			dma_data  <= '0;
		end else begin
			if (dma_push) begin
				dma_valid <= 1'b1;                  // RQ15 RQ22
				dma_data  <= sample_ev ? count_next : count_reg;
			end else if (dma_ready)
				dma_valid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_count_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!armed && !arm_now) |=> $stable(count_reg)) // RQ13
		else $error("count moved while disarmed");

	a_reload_value: assert property (@(posedge pclk) disable iff (!presetn)
		(armed && reload_hit && !arm_now) |=> count_reg == $past(reload_reg)) // RQ5
		else $error("index reload not applied");

	a_single_up: assert property (@(posedge pclk) disable iff (!presetn)
		(armed && !arm_now && mode == epsc_pkg::MODE_SINGLE_EDGE && inc
		 && !reload_hit) |=> count_reg == $past(count_reg) + 32'h1) // RQ1
		else $error("single-edge increment missing");

	a_two_pulse_dn: assert property (@(posedge pclk) disable iff (!presetn)
		(armed && !arm_now && mode == epsc_pkg::MODE_TWO_PULSE && dec)
		|=> count_reg == $past(count_reg) - 32'h1) // RQ12
		else $error("two-pulse decrement missing");

	a_save_latch: assert property (@(posedge pclk) disable iff (!presetn)
		latch_ev |=> save_reg == $past(count_reg) && done_reg) // RQ19
		else $error("save register not latched");

	sequence s_hold_in;
		sep_reg == epsc_pkg::SEP_HOLD && armed && is_sep;
	endsequence
	a_single_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_hold_in ##1 (armed && is_sep) |-> $stable(save_reg)) // RQ21
		else $error("single mode changed held value");

	a_aux_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(sep_reg == epsc_pkg::SEP_RUN && aux_act && !gate_act && armed
		 && is_sep) |=> sep_reg == epsc_pkg::SEP_RUN) // RQ18
		else $error("aux edge disturbed interval");

	a_dma_buf_sep: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_ev && mode == epsc_pkg::MODE_SEP_BUF)
		|=> dma_valid && dma_data == save_reg) // RQ22
		else $error("buffered separation not sent");

	a_sample_cum: assert property (@(posedge pclk) disable iff (!presetn)
		sample_ev |=> dma_valid && dma_data == count_reg) // RQ14
		else $error("sample not cumulative");

endmodule : epsc_counter

`default_nettype wire

// >>> epsc_enc_model.sv
// Encoder and edge-signal source that drives the counter's pins.
// Assumes one bench process calls its tasks, one call at a time.
`timescale 1ns/1ps
`default_nettype none

module epsc_enc_model (
	// Clock
	input  wire logic pclk,
	// Encoder and signal pins
	output var  logic enc_a,
	output var  logic enc_b,
	output var  logic enc_index,
	output var  logic gate_in,
	output var  logic aux_in,
	output var  logic source_in
);
	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Idle low, encoder resting in phase 00
	initial begin
		{enc_a, enc_b, enc_index, gate_in, aux_in, source_in} = 6'h00;
	end

	// Random dwell; never shorter than the pin filter needs
	task automatic dwell();
		repeat (4 + $urandom_range(4)) @(posedge pclk);
	endtask : dwell

	// One quadrature step, only one channel moves at a time
	task automatic quad(input bit fwd);
		@(posedge pclk);
		if (fwd ^ enc_a ^ enc_b) begin
			enc_a <= ~enc_a;
		end else begin
			enc_b <= ~enc_b;
		end
		dwell();
	endtask : quad

	// Level on one pin: 0 a, 1 b, 2 gate, 3 aux, 4 source, 5 index
	task automatic drive(input int pin, input bit v);
		@(posedge pclk);
		case (pin)
			0: enc_a <= v;
			1: enc_b <= v;
			2: gate_in <= v;
			3: aux_in <= v;
			5: enc_index <= v;
			default: source_in <= v;
		endcase
		dwell();
	endtask : drive

	// Full high pulse, so both edges appear
	task automatic pulse(input int pin);
		drive(pin, 1'b1);
		drive(pin, 1'b0);
	endtask : pulse
endmodule : epsc_enc_model
`default_nettype wire

// >>> test_encoder_position_edge_separation_counter.sv
// Self-checking bench for the position and edge-separation counter.
// Assumes epsc_pkg, epsc_counter and epsc_enc_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_encoder_position_edge_separation_counter;
	logic        pclk, presetn, psel, penable, pwrite, dma_ready;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rd, exp_cnt, r;
	logic        er;
	wire logic [31:0] prdata, dma_data;
	wire logic   pready, pslverr, dma_valid;
	wire logic   enc_a, enc_b, enc_index, gate_in, aux_in, source_in;
	int          fail_count, n_checks, m, e, ph, n, k, i;

	epsc_counter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
		.enc_index(enc_index), .gate_in(gate_in), .aux_in(aux_in),
		.source_in(source_in), .dma_valid(dma_valid),
		.dma_ready(dma_ready), .dma_data(dma_data));
	epsc_enc_model u_enc (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b),
		.enc_index(enc_index), .gate_in(gate_in), .aux_in(aux_in),
		.source_in(source_in));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// APB transfer; held until pready is seen high
	task automatic apb(input bit wr, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle bus carries noise; the slave must ignore it
		paddr   <= 8'($urandom);
		pwdata  <= $urandom;
	endtask : apb

	task automatic rd_check(input string what, input logic [7:0] a,
			input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask : rd_check

	// Control word: ext is {src_f, aux_f, gate_f, idx_en, phase}
	function automatic logic [31:0] cw(input logic [2:0] md,
			input logic [5:0] ext, input bit arm);
		return {22'h000000, ext, md, arm};
	endfunction : cw

	// Expected count step for one quadrature transition
	function automatic logic [31:0] delta(input int md,
			input bit pa, pb, na, nb);
		bit ach, fwd;
		ach = pa != na;
		fwd = ach ? (na != pb) : (nb == pa);
		if (md == 2 || (md == 1 && ach) ||
				(md == 0 && ach && (fwd ? na : !na)))
			return fwd ? 32'h1 : 32'hffff_ffff;
		return 32'h0;
	endfunction : delta

	task automatic step(input int md, input bit f);
		bit pa, pb;
		pa = enc_a;
		pb = enc_b;
		u_enc.quad(f);
		exp_cnt += delta(md, pa, pb, enc_a, enc_b);
	endtask : step

	// Pin filter plus register update, with margin
	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask : settle

	// Acts as the DMA controller for one word; looks while valid stands
	task automatic take_dma(input logic [31:0] exp);
		for (int j = 0; j < 40 && dma_valid !== 1'b1; j++) @(negedge pclk);
		check("dma_valid", {31'h0, dma_valid}, 32'h1);
		check("dma_data", dma_data, exp);
		// Random back-pressure before the word is accepted
		repeat ($urandom_range(3)) @(posedge pclk);
		@(posedge pclk);
		dma_ready <= 1'b1;
		@(posedge pclk);
		dma_ready <= 1'b0;
		@(negedge pclk);
		check("dma_drop", {31'h0, dma_valid}, 32'h0);
	endtask : take_dma

	task automatic tally_and_finish();
		if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		repeat (50000) @(posedge pclk);
		fail_count++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, dma_ready, presetn} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		fail_count = 0;
		n_checks = 0;
		void'($urandom(32'h5f4b));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_check("ctrl", epsc_pkg::OFS_CTRL, 32'h0);
		repeat (4) u_enc.quad(1'b1);
		settle();
		rd_check("count idle", epsc_pkg::OFS_COUNT, 32'h0);
		apb(1'b1, epsc_pkg::OFS_COUNT, 32'hffff_ffff);
		rd_check("count ro", epsc_pkg::OFS_COUNT, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		check("pslverr", {31'h0, er}, 32'h1);
		check("unmapped", rd, 32'h0);
		// Random walks in every decoding mode, reversals included
		for (m = 0; m < 4; m++) begin
			apb(1'b1, epsc_pkg::OFS_CTRL, 32'h0);
			while (enc_a | enc_b) u_enc.quad(1'b1);
			apb(1'b1, epsc_pkg::OFS_CTRL, cw(3'(m), 6'h00, 1'b1));
			exp_cnt = 32'h0;
			repeat (16) begin
				k = $urandom_range(1);
				if (m == 3) begin
					u_enc.pulse(k);
					exp_cnt += k ? 32'hffff_ffff : 32'h1;
				end else step(m, k[0]);
			end
			settle();
			rd_check("count", epsc_pkg::OFS_COUNT, exp_cnt);
		end
		// Index reload in each of the four phases
		r = $urandom;
		apb(1'b1, epsc_pkg::OFS_RELOAD, r);
		for (ph = 0; ph < 4; ph++) begin
			apb(1'b1, epsc_pkg::OFS_CTRL,
				cw(epsc_pkg::MODE_QUAD_EDGE, {4'h1, ph[1:0]}, 1'b1));
			while ({enc_a, enc_b} != ph[1:0]) u_enc.quad(1'b1);
			repeat (3) u_enc.quad(1'b1);
			u_enc.drive(5, 1'b1);
			u_enc.quad(1'b1);
			u_enc.drive(5, 1'b0);
			settle();
			rd_check("reload", epsc_pkg::OFS_COUNT, r);
			u_enc.quad(1'b1);
			settle();
			rd_check("after reload", epsc_pkg::OFS_COUNT, r + 1);
		end
		// Sampled position on rising, then falling gate edges
		for (e = 0; e < 2; e++) begin
			apb(1'b1, epsc_pkg::OFS_CTRL, 32'h0);
			apb(1'b1, epsc_pkg::OFS_CTRL,
				cw(epsc_pkg::MODE_QUAD_EDGE, {2'b00, e[0], 3'h0}, 1'b1));
			exp_cnt = 32'h0;
			repeat (2) begin
				repeat (5) step(2, $urandom_range(1));
				u_enc.pulse(2);
				take_dma(exp_cnt);
			end
		end
		// Single separation, rising then falling active edges
		for (e = 0; e < 2; e++) begin
			apb(1'b1, epsc_pkg::OFS_CTRL, 32'h0);
			apb(1'b1, epsc_pkg::OFS_CTRL, cw(epsc_pkg::MODE_SEP_SINGLE,
				{e[0], e[0], e[0], 3'h0}, 1'b1));
			n = 1 + $urandom_range(5);
			u_enc.pulse(3);
			repeat (n) u_enc.pulse(4);
			u_enc.pulse(3);
			repeat (2) u_enc.pulse(4);
			u_enc.pulse(2);
			settle();
			rd_check("save", epsc_pkg::OFS_SAVE, n + 2);
			rd_check("status", epsc_pkg::OFS_STATUS, 32'h2);
			u_enc.pulse(3);
			u_enc.pulse(4);
			u_enc.pulse(2);
			settle();
			rd_check("held", epsc_pkg::OFS_SAVE, n + 2);
		end
		// Buffered separation; a stale word is drained first
		dma_ready <= 1'b1;
		@(posedge pclk);
		dma_ready <= 1'b0;
		apb(1'b1, epsc_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, epsc_pkg::OFS_CTRL,
			cw(epsc_pkg::MODE_SEP_BUF, 6'h00, 1'b1));
		u_enc.pulse(3);
		for (i = 0; i < 3; i++) begin
			n = $urandom_range(6);
			repeat (n) u_enc.pulse(4);
			u_enc.pulse(2);
			take_dma(n);
			u_enc.pulse(2);
		end
		tally_and_finish();
	end
endmodule : test_encoder_position_edge_separation_counter
`default_nettype wire
